// *** design/seq_exec_pkg.sv ***
// Package with constants, instruction formats and carrier types of the sequencer instruction executor.
package seq_exec_pkg;

  // Program, register bank and APB address widths.
  localparam int PC_W = 10;
  localparam int BANK_AW = 10;
  localparam int APB_AW = 12;

  // Opcodes.
  localparam logic [3:0] OP_MASK_PAGE0 = 4'h0;
  localparam logic [3:0] OP_WRITE_IMM = 4'h1;
  localparam logic [3:0] OP_MASK_IMM = 4'h2;
  localparam logic [3:0] OP_VOUT = 4'h3;
  localparam logic [3:0] OP_REGULATOR_CONTROL_VALUE = 4'h4;
  localparam logic [3:0] OP_MASK_SREG = 4'h5;
  localparam logic [3:0] OP_SREG_READ = 4'h6;
  localparam logic [3:0] OP_WAIT = 4'h7;
  localparam logic [3:0] OP_END = 4'hc;
  localparam logic [3:0] OP_BIT_PAGE0 = 4'hd;
  localparam logic [3:0] OP_WIN_PAGE0 = 4'he;
  localparam logic [3:0] OP_SREG_IMM = 4'hf;

  // Wait types and the hardwired condition.
  localparam logic [1:0] WT_LOW = 2'h0;
  localparam logic [1:0] WT_HIGH = 2'h1;
  localparam logic [1:0] WT_RISE = 2'h2;
  localparam logic [1:0] WT_FALL = 2'h3;
  localparam logic [5:0] COND_ONE = 6'h3f;
  localparam int NUM_COND_PINS = 63;

  // Delay modes of the regulator control write.
  localparam logic [1:0] DM_MATCH_EN = 2'h0;
  localparam logic [1:0] DM_MATCH_ALL = 2'h1;

  // Regulator control field positions.
  localparam int VC_EN = 0;
  localparam int VC_SETPOINT_SELECTOR = 3;

  // Register bank address that holds the delay step code.
  localparam logic [BANK_AW-1:0] STEP_REG_ADDR = 10'h0f0;

  // Step timing: one step code unit lasts STEP_UNIT_NS.
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_UNIT_NS = 1000;
  localparam int STEP_UNIT_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB register offsets and reset values.
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] START_OFS = 12'h004;
  localparam logic [APB_AW-1:0] STEP_OFS = 12'h008;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h00c;
  localparam logic [APB_AW-1:0] EXT_OFS = 12'h010;
  localparam logic [APB_AW-1:0] SCRATCH_OFS = 12'h014;
  localparam logic [7:0] DFLT_STEP_RST = 8'h0a;
  localparam logic [PC_W-1:0] START_ADDR_RST = 10'h000;

  // Instruction formats, opcode in the low nibble.
  typedef struct packed {
    logic [1:0] pad; logic [7:0] mask; logic [7:0] data; logic [9:0] addr; logic [3:0] op;
  } mask_instr_t;
  typedef struct packed {
    logic [3:0] pad; logic [7:0] mask; logic [7:0] data; logic [7:0] addr; logic [3:0] op;
  } p0_instr_t;
  typedef struct packed {
    logic [15:0] pad; logic data; logic [2:0] bit_sel; logic [7:0] addr; logic [3:0] op;
  } bit_instr_t;
  typedef struct packed {
    logic [6:0] pad; logic [2:0] shift; logic [4:0] mask; logic [4:0] data; logic [7:0] addr; logic [3:0] op;
  } win_instr_t;
  typedef struct packed {
    logic [9:0] pad; logic [5:0] delay; logic [7:0] vout; logic [1:0] setpoint_selector; logic [1:0] buck; logic [3:0] op;
  } vout_instr_t;
  typedef struct packed {
    logic [5:0] pad; logic [1:0] mode; logic [5:0] delay; logic [5:0] mask; logic [5:0] value;
    logic [1:0] buck; logic [3:0] op;
  } regulator_control_value_instr_t;
  typedef struct packed {
    logic [7:0] pad; logic [7:0] mask; logic [9:0] addr; logic [1:0] sreg; logic [3:0] op;
  } sreg_instr_t;
  typedef struct packed {
    logic [2:0] pad; logic [9:0] dest; logic ext; logic [5:0] timeout; logic [1:0] typ;
    logic [5:0] cond; logic [3:0] op;
  } wait_instr_t;

  // Register bank command and per-regulator controls.
  typedef struct packed {
    logic req; logic we; logic [BANK_AW-1:0] addr; logic [7:0] wdata;
  } bank_cmd_t;
  typedef struct packed {
    logic [5:0] regulator_control_value; logic [7:0] vset1; logic [7:0] vset2;
  } buck_t;

endpackage : seq_exec_pkg

// *** design/sequencer_instruction_executor.sv ***
// Sequencer instruction executor with APB control registers, register bank master and regulator controls.
//
// Summary of operation
// - Masked write stores data into addressed register; mask ones keep old bits.
// - Page-zero masked write does the same, address always in page 0.
// - Bit write replaces one selected bit of a page-zero register.
// - Window write merges 5-bit data and 5-bit mask; mask ones are don't-care.
// - Window data and mask shift left by shift operand before applying.
// - Output-voltage write sets one of two regulator setpoints after encoded delay.
// - Selector 0 first, 1 second, 2 active, 3 inactive setpoint.
// - Delay counts 0 to 63 steps; action performed when the count is reached.
// - Step size is default setting unless an earlier sequence instruction replaced it.
// - Regulator control write applies masked value to the six control fields.
// - Delay mode: 0 if enable differs, 1 if any bit differs, 2 always.
// - Scratch-to-register writes scratch content under mask to addressed register.
// - Scratch load reads addressed register into one of four scratch registers.
// - Scratch immediate stores its data byte in selected scratch register.
// - Wait stalls until condition level or edge matches, or timeout expires.
// - Timeout jumps to destination; met condition continues with next instruction.
// - Destination flag 0 is program address, 1 an external state identifier.
// - Condition 63 is constant one; low wait with zero timeout jumps.
// - Timeout is 0 to 63 steps of the current step size.
// - End instruction, opcode 0xc, stops the running task.
`timescale 1ns/1ps
`default_nettype none

module sequencer_instruction_executor
  import seq_exec_pkg::*;
#(
  parameter int STEP_CYCLES_PER_UNIT = seq_exec_pkg::STEP_UNIT_CYCLES
) (
  input wire logic pclk, // Clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [seq_exec_pkg::APB_AW-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic mem_req, // Program fetch request.
  output logic [seq_exec_pkg::PC_W-1:0] mem_addr, // Program fetch address.
  input wire logic [31:0] mem_rdata, // Fetched instruction word.
  input wire logic mem_ack, // Fetch completes.
  output seq_exec_pkg::bank_cmd_t bank, // Register bank command.
  input wire logic [7:0] bank_rdata, // Register bank read data.
  input wire logic bank_ack, // Register bank command taken.
  input wire logic [seq_exec_pkg::NUM_COND_PINS-1:0] cond_in, // Wait conditions 0 to 62.
  output seq_exec_pkg::buck_t [3:0] buck, // Regulator controls and setpoints.
  output logic seq_busy, // Sequence running.
  output logic seq_done, // Pulse when an end instruction finishes a task.
  output logic ext_valid, // Pulse when a wait jumps to an external state.
  output logic [seq_exec_pkg::PC_W-1:0] ext_state // External state identifier.
);
  import seq_exec_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EXEC, S_READ, S_WRITE, S_DELAY, S_WAIT} state_t;

  typedef struct packed {
    state_t st;
    logic [PC_W-1:0] pc;
    logic [31:0] instr;
    bank_cmd_t bank;
    logic mem_req;
    logic [PC_W-1:0] mem_addr;
    logic [7:0] wr_data;
    logic [7:0] wr_keep;
    logic [3:0][7:0] sreg;
    logic [7:0] step;
    logic [15:0] pre;
    logic [5:0] cnt;
    logic [5:0] lim;
    logic cond_prev;
    logic [NUM_COND_PINS-1:0] sync1;
    logic [NUM_COND_PINS-1:0] sync2;
    buck_t [3:0] buck;
    logic busy;
    logic done;
    logic ext_valid;
    logic [PC_W-1:0] ext_state;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [PC_W-1:0] start_addr;
    logic [7:0] dflt_step;
  } exec_state_t;

  localparam exec_state_t RESET_STATE = '{st: S_IDLE, step: DFLT_STEP_RST, dflt_step: DFLT_STEP_RST,
                                          start_addr: START_ADDR_RST, default: '0};

  exec_state_t q;
  exec_state_t d;

  // Keep-merge used by every masked write path and by the regulator control write.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] keep);
    return (old & keep) | (nw & ~keep);
  endfunction : merge

  // True when the selected setpoint is the second one.
  function automatic logic pick_second(input logic [1:0] sel, input logic active_second);
    case (sel)
      2'h0: return 1'b0;
      2'h1: return 1'b1;
      2'h2: return active_second;
      default: return ~active_second;
    endcase
  endfunction : pick_second

  // APB register decode; 3'h7 is an unmapped address.
  function automatic logic [2:0] reg_sel(input logic [APB_AW-1:0] a);
    case (a)
      CTRL_OFS: return 3'h0;
      START_OFS: return 3'h1;
      STEP_OFS: return 3'h2;
      STATUS_OFS: return 3'h3;
      EXT_OFS: return 3'h4;
      SCRATCH_OFS: return 3'h5;
      default: return 3'h7;
    endcase
  endfunction : reg_sel

  mask_instr_t mi;
  p0_instr_t p0;
  bit_instr_t bi;
  win_instr_t wn;
  vout_instr_t vo;
  regulator_control_value_instr_t vc;
  sreg_instr_t si;
  wait_instr_t wi;
  logic [63:0] cond_all;
  logic cond_cur;
  logic cond_met;
  logic step_tick;
  logic [15:0] step_cycles;

  assign mi = mask_instr_t'(q.instr);
  assign p0 = p0_instr_t'(q.instr);
  assign bi = bit_instr_t'(q.instr);
  assign wn = win_instr_t'(q.instr);
  assign vo = vout_instr_t'(q.instr);
  assign vc = regulator_control_value_instr_t'(q.instr);
  assign si = sreg_instr_t'(q.instr);
  assign wi = wait_instr_t'(q.instr);

  // Condition 63 reads as constant one.
  assign cond_all = {1'b1, q.sync2};
  assign cond_cur = cond_all[wi.cond];
  assign step_cycles = 16'(({8'h00, q.step} + 16'h0001) * 16'(STEP_CYCLES_PER_UNIT));
  assign step_tick = (q.pre == step_cycles - 16'h0001);

  // Level checks on the current value, edge checks against the value sampled one cycle earlier.
  always_comb begin
    case (wi.typ)
      WT_LOW: cond_met = ~cond_cur;
      WT_HIGH: cond_met = cond_cur;
      WT_RISE: cond_met = cond_cur & ~q.cond_prev;
      default: cond_met = ~cond_cur & q.cond_prev;
    endcase
  end

  always_comb begin
    logic [5:0] new_vc;
    logic [1:0] b;
    logic need_delay;
    logic [7:0] full_vc;
    new_vc = '0;
    full_vc = '0;
    b = '0;
    need_delay = 1'b0;
    d = q;
    d.done = 1'b0;
    d.ext_valid = 1'b0;
    d.sync1 = cond_in;
    d.sync2 = q.sync1;
    d.cond_prev = cond_cur;
    case (q.st)
      S_IDLE: begin
        d.busy = 1'b0;
      end
      S_FETCH: begin
        d.mem_req = 1'b1;
        d.mem_addr = q.pc;
        if (q.mem_req && mem_ack) begin
          d.mem_req = 1'b0;
          d.instr = mem_rdata;
          d.st = S_EXEC;
        end
      end
      S_EXEC: begin
        d.pc = q.pc + 10'h001;
        d.st = S_FETCH;
        d.cnt = '0;
        d.pre = '0;
        case (mi.op)
          OP_MASK_IMM, OP_WRITE_IMM: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: mi.addr, wdata: 8'h00};
            d.wr_data = mi.data;
            d.wr_keep = (mi.op == OP_WRITE_IMM) ? 8'h00 : mi.mask;
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_MASK_PAGE0: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: {2'b00, p0.addr}, wdata: 8'h00};
            d.wr_data = p0.data;
            d.wr_keep = p0.mask;
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_BIT_PAGE0: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: {2'b00, bi.addr}, wdata: 8'h00};
            d.wr_data = {8{bi.data}};
            d.wr_keep = ~(8'h01 << bi.bit_sel);
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_WIN_PAGE0: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: {2'b00, wn.addr}, wdata: 8'h00};
            d.wr_data = {3'b000, wn.data} << wn.shift;
            d.wr_keep = ~({3'b000, ~wn.mask} << wn.shift);
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_MASK_SREG: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: si.addr, wdata: 8'h00};
            d.wr_data = q.sreg[si.sreg];
            d.wr_keep = si.mask;
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_SREG_READ: begin
            d.bank = '{req: 1'b1, we: 1'b0, addr: si.addr, wdata: 8'h00};
            d.pc = q.pc;
            d.st = S_READ;
          end
          OP_SREG_IMM: begin
            d.sreg[si.sreg] = si.addr[7:0];
          end
          OP_VOUT: begin
            d.lim = vo.delay;
            d.pc = q.pc;
            d.st = S_DELAY;
          end
          OP_REGULATOR_CONTROL_VALUE: begin
            b = vc.buck;
            full_vc = merge({2'b00, q.buck[b].regulator_control_value}, {2'b00, vc.value}, {2'b11, vc.mask});
            new_vc = full_vc[5:0];
            case (vc.mode)
              DM_MATCH_EN: need_delay = (new_vc[VC_EN] != q.buck[b].regulator_control_value[VC_EN]);
              DM_MATCH_ALL: need_delay = (new_vc != q.buck[b].regulator_control_value);
              default: need_delay = 1'b1;
            endcase
            d.lim = need_delay ? vc.delay : 6'h00;
            d.pc = q.pc;
            d.st = S_DELAY;
          end
          OP_WAIT: begin
            d.lim = wi.timeout;
            d.pc = q.pc;
            d.st = S_WAIT;
          end
          OP_END: begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.pc = q.pc;
            d.st = S_IDLE;
          end
          default: begin
          end
        endcase
      end
      S_READ: begin
        if (bank_ack) begin
          if (si.op == OP_SREG_READ) begin
            d.sreg[si.sreg] = bank_rdata;
            d.bank.req = 1'b0;
            d.pc = q.pc + 10'h001;
            d.st = S_FETCH;
          end else begin
            d.bank.we = 1'b1;
            d.bank.wdata = merge(bank_rdata, q.wr_data, q.wr_keep);
            d.st = S_WRITE;
          end
        end
      end
      S_WRITE: begin
        if (bank_ack) begin
          d.bank.req = 1'b0;
          d.bank.we = 1'b0;
          // A write to the step register replaces the step size for the rest of the sequence.
          if (q.bank.addr == STEP_REG_ADDR) begin
            d.step = q.bank.wdata;
          end
          d.pc = q.pc + 10'h001;
          d.st = S_FETCH;
        end
      end
      S_DELAY: begin
        if (q.cnt == q.lim) begin
          if (vo.op == OP_VOUT) begin
            b = vo.buck;
            if (pick_second(vo.setpoint_selector, q.buck[b].regulator_control_value[VC_SETPOINT_SELECTOR])) begin
              d.buck[b].vset2 = vo.vout;
            end else begin
              d.buck[b].vset1 = vo.vout;
            end
          end else begin
            b = vc.buck;
            full_vc = merge({2'b00, q.buck[b].regulator_control_value}, {2'b00, vc.value}, {2'b11, vc.mask});
            d.buck[b].regulator_control_value = full_vc[5:0];
          end
          d.pc = q.pc + 10'h001;
          d.st = S_FETCH;
        end else if (step_tick) begin
          d.pre = '0;
          d.cnt = q.cnt + 6'h01;
        end else begin
          d.pre = q.pre + 16'h0001;
        end
      end
      S_WAIT: begin
        if (cond_met) begin
          d.pc = q.pc + 10'h001;
          d.st = S_FETCH;
        end else if (q.cnt == q.lim) begin
          if (wi.ext) begin
            d.ext_state = wi.dest;
            d.ext_valid = 1'b1;
            d.busy = 1'b0;
            d.st = S_IDLE;
          end else begin
            d.pc = wi.dest;
            d.st = S_FETCH;
          end
        end else if (step_tick) begin
          d.pre = '0;
          d.cnt = q.cnt + 6'h01;
        end else begin
          d.pre = q.pre + 16'h0001;
        end
      end
      default: d.st = S_IDLE;
    endcase

    // APB slave: one wait state, answer in the second access cycle.
    d.pready = psel & penable & ~q.pready;
    if (psel && penable && !q.pready) begin
      d.pslverr = (reg_sel(paddr) == 3'h7);
      case (reg_sel(paddr))
        3'h1: d.prdata = {22'h0, q.start_addr};
        3'h2: d.prdata = {24'h0, q.dflt_step};
        3'h3: d.prdata = {6'h0, q.pc, 15'h0, q.busy};
        3'h4: d.prdata = {22'h0, q.ext_state};
        3'h5: d.prdata = q.sreg;
        default: d.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && q.pready && pwrite) begin
      case (reg_sel(paddr))
        3'h0: begin
          // A start while a sequence runs is ignored.
          if (pwdata[0] && q.st == S_IDLE) begin
            d.pc = q.start_addr;
            d.step = q.dflt_step;
            d.busy = 1'b1;
            d.st = S_FETCH;
          end
        end
        3'h1: d.start_addr = pwdata[PC_W-1:0];
        3'h2: d.dflt_step = pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mem_req = q.mem_req;
  assign mem_addr = q.mem_addr;
  assign bank = q.bank;
  assign buck = q.buck;
  assign seq_busy = q.busy;
  assign seq_done = q.done;
  assign ext_valid = q.ext_valid;
  assign ext_state = q.ext_state;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fetch_held: assert property (q.mem_req && !mem_ack |=> q.mem_req && $stable(q.mem_addr))
    else $error("fetch request dropped before acknowledge");
  a_one_at_time: assert property (q.bank.req |-> !q.mem_req)
    else $error("fetch overlaps a register access");
  a_end_stops: assert property (q.st == S_EXEC && mi.op == OP_END |=> !q.busy && q.done ##1 !q.done)
    else $error("end instruction did not stop the task");
  a_page_zero: assert property (q.bank.req && (mi.op == OP_MASK_PAGE0 || mi.op == OP_BIT_PAGE0 ||
                                mi.op == OP_WIN_PAGE0) |-> q.bank.addr[9:8] == 2'b00)
    else $error("page-zero write left page zero");
  a_keep_merge: assert property (q.st == S_WRITE && q.bank.we |->
                                 (q.bank.wdata & ~q.wr_keep) == (q.wr_data & ~q.wr_keep))
    else $error("unmasked bits not written with instruction data");
  a_keep_old: assert property ($rose(q.bank.we) |->
                               (q.bank.wdata & q.wr_keep) == ($past(bank_rdata) & q.wr_keep))
    else $error("protected bits lost their previous value");
  a_read_first: assert property ($rose(q.bank.we) |-> $past(q.bank.req) && $past(bank_ack))
    else $error("write issued without a preceding read");
  a_scratch_imm: assert property (q.st == S_EXEC && si.op == OP_SREG_IMM |=>
                                  q.sreg[$past(si.sreg)] == $past(si.addr[7:0]))
    else $error("scratch immediate not stored");
  a_jump_taken: assert property (q.st == S_EXEC && wi.op == OP_WAIT && wi.cond == COND_ONE &&
                                 wi.typ == WT_LOW && wi.timeout == 6'h00 && !wi.ext |=>
                                 ##1 (q.st == S_FETCH && q.pc == wi.dest))
    else $error("unconditional jump not taken");
  a_wait_stall: assert property (q.st == S_WAIT && !cond_met && q.cnt != q.lim |=> q.st == S_WAIT)
    else $error("wait left early");
  a_delay_hold: assert property (q.st == S_DELAY && q.cnt != q.lim |=> $stable(q.buck))
    else $error("regulator changed before delay expired");

endmodule : sequencer_instruction_executor

`default_nettype wire

// *** tb/seq_partner.sv ***
// Partner model: program memory and internal register bank answering after random stalls.
`timescale 1ns/1ps
`default_nettype none
module seq_partner
  import seq_exec_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic mem_req, // Fetch request.
  input wire logic [seq_exec_pkg::PC_W-1:0] mem_addr, // Fetch address.
  output logic [31:0] mem_rdata, // Instruction word.
  output logic mem_ack, // Fetch done.
  input wire seq_exec_pkg::bank_cmd_t bank, // Bank command.
  output logic [7:0] bank_rdata, // Bank read data.
  output logic bank_ack // Bank command taken.
);
  import seq_exec_pkg::*;
  logic [31:0] prog [1024];
  logic [7:0] regs [1024];
  logic [31:0] rnd;
  int seed = 32;
  // Outside an ack the data lines show the inverse of the last value, so a late sample reads garbage.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      bank_ack <= 1'b0;
      mem_rdata <= 32'h0;
      bank_rdata <= 8'h0;
    end else begin
      rnd = $random(seed);
      mem_ack <= mem_req && !mem_ack && rnd[0];
      mem_rdata <= (mem_req && !mem_ack && rnd[0]) ? prog[mem_addr] : ~mem_rdata;
      bank_ack <= bank.req && !bank_ack && rnd[1];
      bank_rdata <= (bank.req && !bank_ack && rnd[1]) ? regs[bank.addr] : ~bank_rdata;
      if (bank.req && bank_ack && bank.we) regs[bank.addr] <= bank.wdata;
    end
  end
endmodule : seq_partner
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the sequencer instruction executor against a reference register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import seq_exec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, mem_rdata;
  logic pready, pslverr, mem_req, mem_ack, bank_ack, seq_busy, seq_done, ext_valid, err;
  logic [PC_W-1:0] mem_addr, ext_state;
  logic [7:0] bank_rdata, s0, s1;
  logic [NUM_COND_PINS-1:0] cond_in = '0;
  bank_cmd_t bank;
  buck_t [3:0] buck;
  logic [7:0] exp_bank [1024];
  logic [9:0] al [7] = '{10'h3ff, 10'h0ff, 10'h1ff, 10'h02a, 10'h01d, 10'h054, 10'h100};
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32;
  int cyc;
  int k;
  always #4 pclk = ~pclk;
  sequencer_instruction_executor #(.STEP_CYCLES_PER_UNIT(2)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .bank,
    .bank_rdata, .bank_ack, .cond_in, .buck, .seq_busy, .seq_done, .ext_valid, .ext_state);
  seq_partner partner_u (.pclk, .presetn, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .bank, .bank_rdata,
    .bank_ack);
  task automatic conclude();
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] mrg(input logic [7:0] o, input logic [7:0] d, input logic [7:0] k);
    return (o & k) | (d & ~k);
  endfunction : mrg
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Starts a task and counts cycles until it ends or hands over to an external state.
  task automatic run(input logic [9:0] start);
    apb(1'b1, START_OFS, {22'h0, start});
    apb(1'b1, CTRL_OFS, 32'h1);
    cyc = 0;
    while (seq_done !== 1'b1 && ext_valid !== 1'b1) begin
      @(posedge pclk);
      cyc++;
      if (cyc > 5000) begin
        mismatches++;
        conclude();
      end
    end
  endtask : run
  initial begin
    for (int i = 0; i < 1024; i++) begin
      cyc = $random(seed);
      partner_u.regs[i] = cyc[7:0];
      exp_bank[i] = cyc[7:0];
    end
    partner_u.prog[0] = {18'h0, 8'hc3, 2'h0, OP_SREG_IMM};
    partner_u.prog[1] = mask_instr_t'{2'h0, 8'hf0, 8'h80, 10'h3ff, OP_MASK_IMM};
    partner_u.prog[2] = p0_instr_t'{4'h0, 8'hf0, 8'h0f, 8'hff, OP_MASK_PAGE0};
    partner_u.prog[3] = bit_instr_t'{16'h0, 1'b0, 3'h7, 8'h2a, OP_BIT_PAGE0};
    partner_u.prog[4] = win_instr_t'{7'h0, 3'h2, 5'h13, 5'h08, 8'h1d, OP_WIN_PAGE0};
    partner_u.prog[5] = sreg_instr_t'{8'h0, 8'h00, 10'h3ff, 2'h1, OP_SREG_READ};
    partner_u.prog[6] = sreg_instr_t'{8'h0, 8'hf0, 10'h054, 2'h0, OP_MASK_SREG};
    partner_u.prog[7] = regulator_control_value_instr_t'{6'h0, 2'h2, 6'h00, 6'h00, 6'h09, 2'h0, OP_REGULATOR_CONTROL_VALUE};
    partner_u.prog[8] = vout_instr_t'{10'h0, 6'h01, 8'h41, 2'h2, 2'h0, OP_VOUT};
    partner_u.prog[9] = vout_instr_t'{10'h0, 6'h00, 8'h42, 2'h3, 2'h0, OP_VOUT};
    partner_u.prog[10] = vout_instr_t'{10'h0, 6'h00, 8'h43, 2'h0, 2'h1, OP_VOUT};
    partner_u.prog[11] = vout_instr_t'{10'h0, 6'h00, 8'h44, 2'h1, 2'h2, OP_VOUT};
    partner_u.prog[12] = wait_instr_t'{3'h0, 10'h00e, 1'b0, 6'h00, WT_LOW, COND_ONE, OP_WAIT};
    partner_u.prog[13] = mask_instr_t'{2'h0, 8'h00, 8'hff, 10'h100, OP_MASK_IMM};
    partner_u.prog[14] = wait_instr_t'{3'h0, 10'h00f, 1'b0, 6'h05, WT_HIGH, COND_ONE, OP_WAIT};
    partner_u.prog[15] = {28'h0, OP_END};
    partner_u.prog[32] = wait_instr_t'{3'h0, 10'h155, 1'b1, 6'h04, WT_LOW, COND_ONE, OP_WAIT};
    k = $unsigned($random(seed)) % NUM_COND_PINS;
    partner_u.prog[64] = wait_instr_t'{3'h0, 10'h044, 1'b0, 6'h3f, WT_RISE, 6'(k), OP_WAIT};
    partner_u.prog[65] = {18'h0, 8'h5a, 2'h2, OP_SREG_IMM};
    partner_u.prog[66] = wait_instr_t'{3'h0, 10'h044, 1'b0, 6'h3f, WT_FALL, 6'(k), OP_WAIT};
    partner_u.prog[67] = {18'h0, 8'ha5, 2'h3, OP_SREG_IMM};
    partner_u.prog[68] = {28'h0, OP_END};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, STEP_OFS, 32'h0);
    chk("step code", 32'h0a, q);
    apb(1'b0, 12'h100, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    run(10'h000);
    s0 = 8'hc3;
    exp_bank[10'h3ff] = mrg(exp_bank[10'h3ff], 8'h80, 8'hf0);
    exp_bank[10'h0ff] = mrg(exp_bank[10'h0ff], 8'h0f, 8'hf0);
    exp_bank[10'h02a] = mrg(exp_bank[10'h02a], 8'h00, 8'h7f);
    exp_bank[10'h01d] = mrg(exp_bank[10'h01d], 8'h20, 8'hcf);
    s1 = exp_bank[10'h3ff];
    exp_bank[10'h054] = mrg(exp_bank[10'h054], s0, 8'hf0);
    foreach (al[i]) chk("bank register", exp_bank[al[i]], partner_u.regs[al[i]]);
    chk("control", 32'h09, buck[0].regulator_control_value);
    chk("active setpoint", 32'h41, buck[0].vset2);
    chk("inactive setpoint", 32'h42, buck[0].vset1);
    chk("first setpoint", 32'h43, buck[1].vset1);
    chk("second setpoint", 32'h44, buck[2].vset2);
    chk("done busy", 32'h0, {31'h0, seq_busy});
    apb(1'b0, SCRATCH_OFS, 32'h0);
    chk("scratch", {16'h0, s1, s0}, {16'h0, q[15:0]});
    run(10'h020);
    chk("ext valid", 32'h1, {31'h0, ext_valid});
    chk("ext state", 32'h155, {22'h0, ext_state});
    chk("timeout span", 32'h1, {31'h0, cyc >= 86 && cyc <= 120});
    @(posedge pclk);
    chk("ext busy", 32'h0, {31'h0, seq_busy});
    // A random condition pin rises and later falls; a timeout would skip the scratch writes.
    fork
      run(10'h040);
      begin
        repeat (40) @(posedge pclk);
        cond_in[k] <= 1'b1;
        repeat (60) @(posedge pclk);
        cond_in[k] <= 1'b0;
      end
    join
    chk("edge wait span", 32'h1, {31'h0, cyc < 300});
    apb(1'b0, SCRATCH_OFS, 32'h0);
    chk("edge wait scratch", {8'ha5, 8'h5a, s1, s0}, q);
    conclude();
  end
endmodule : testbench
`default_nettype wire
